// ===== pll_config_register_bank.sv
// Purpose: Two-wire serial slave with the four PLL configuration registers.
// Assumes: scl_clk is the bus clock pin; sys_clk is far faster than scl_clk.
// Notes:   Bit transfer runs on scl_clk; start and stop are seen on sys_clk.
`timescale 1ns/1ps
`default_nettype none

module pll_config_register_bank (
  // Clocks and reset
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic                 scl_clk,
  // Serial data pin
  input  wire logic                 sda_in,
  output var  logic                 sda_out,
  output var  logic                 sda_oe,
  // Address straps
  input  wire logic                 addr_pin_hi,
  input  wire logic                 addr_pin_lo,
  // PLL status sources
  input  wire logic                 refclk_status,
  input  wire logic                 refloss_status,
  input  wire logic                 lock_status,
  // Status pins
  output var  logic                 stat_a,
  output var  logic                 stat_b,
  // Loop filter and pump
  output var  logic [2:0]           loop_cap_sel,
  output var  logic [2:0]           loop_res_sel,
  output var  logic [2:0]           pump_current_sel,
  // Dividers
  output var  logic [13:0]          ref_divider_val,
  output var  logic [14:0]          ref_div_ratio,
  output var  logic [9:0]           feedback_divider_a_val,
  output var  logic [10:0]          fb_a_ratio,
  output var  logic [7:0]           feedback_divider_b_val,
  output var  logic [8:0]           fb_b_ratio,
  // Core control
  output var  logic                 core_reset,
  output var  logic                 divider_sync_force,
  output var  logic                 cal_enable,
  output var  logic [1:0]           prescaler_one_sel,
  output var  logic [1:0]           prescaler_two_sel,
  output var  logic [2:0]           prescaler_one_ratio,
  output var  logic [2:0]           prescaler_two_ratio
);
  import pll_cfg_pkg::*;

  function automatic logic [2:0] ps_ratio(input logic [1:0] code);
    logic [2:0] r;
    r = 3'h0;
    if (code == 2'h0) begin
      r = 3'h4;
    end else if (code == 2'h1) begin
      r = 3'h5;
    end else if (code == 2'h2) begin
      r = 3'h6;
    end
    return r;
  endfunction

  // System domain: pin synchronisers.
  logic [1:0] scl_sync_ff, sda_sync_ff;
  logic       sda_prev_ff;
  logic [2:0] stat_sync1_ff, stat_sync2_ff;
  logic [1:0] strap_sync1_ff, strap_sync2_ff;
  logic [1:0] strap_ff;
  logic [2:0] strap_done_ff;
  logic       frame_clr_ff;
  logic       start_seen, stop_seen;

  // System domain: crossings and registers.
  logic [2:0]  wr_sync_ff, rd_sync_ff;
  logic        rd_ack_tgl_ff;
  logic [15:0] rd_word_ff;
  logic [15:0] reg_loop_ff, reg_div1_ff, reg_div2_ff, reg_ctrl_ff;
  logic        wr_pulse, rd_pulse;
  logic [15:0] sel_word;

  // Link domain.
  link_state_t link_state_ff;
  logic        link_rst;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  dat_hi_ff;
  logic [15:0] reg_addr_ff, wr_data_ff, tx_word_ff;
  logic        tx_byte_ff;
  logic        wr_tgl_ff, rd_req_tgl_ff;
  logic [1:0]  ack_sync_ff;
  logic [1:0]  lstrap_sync1_ff, lstrap_sync2_ff;
  logic        addr_match;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      scl_sync_ff <= 2'h3;
      sda_sync_ff <= 2'h3;
      sda_prev_ff <= 1'h1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_clk};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      sda_prev_ff <= sda_sync_ff[1];
    end
  end

  // Start and stop are both edges of data while the clock is high.
  assign start_seen = scl_sync_ff[1] & sda_prev_ff & ~sda_sync_ff[1];
  assign stop_seen  = scl_sync_ff[1] & ~sda_prev_ff & sda_sync_ff[1];

  // The frame clear is released only once the clock is seen low, so the link
  // logic leaves reset far from any clock edge.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      frame_clr_ff <= 1'h1;
    end else if (start_seen || stop_seen) begin
      frame_clr_ff <= 1'h1;
    end else if (!scl_sync_ff[1]) begin
      frame_clr_ff <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      strap_sync1_ff <= 2'h0;
      strap_sync2_ff <= 2'h0;
      strap_ff       <= 2'h0;
      strap_done_ff  <= 3'h0;
    end else begin
      strap_sync1_ff <= {addr_pin_hi, addr_pin_lo};
      strap_sync2_ff <= strap_sync1_ff;
      strap_done_ff  <= {strap_done_ff[1:0], 1'h1};
      if (strap_done_ff[1] && !strap_done_ff[2]) begin
        strap_ff <= strap_sync2_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_sync_ff <= 3'h0;
      rd_sync_ff <= 3'h0;
    end else begin
      wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      rd_sync_ff <= {rd_sync_ff[1:0], rd_req_tgl_ff};
    end
  end

  assign wr_pulse = wr_sync_ff[2] ^ wr_sync_ff[1];
  assign rd_pulse = rd_sync_ff[2] ^ rd_sync_ff[1];

  // Addresses outside 0 to 3 read as zero and ignore writes.
  always_comb begin
    if (reg_addr_ff == REG_LOOP_IDX) begin
      sel_word = reg_loop_ff;
    end else if (reg_addr_ff == REG_DIV1_IDX) begin
      sel_word = reg_div1_ff;
    end else if (reg_addr_ff == REG_DIV2_IDX) begin
      sel_word = reg_div2_ff;
    end else if (reg_addr_ff == REG_CTRL_IDX) begin
      sel_word = reg_ctrl_ff;
    end else begin
      sel_word = 16'h0000;
    end
  end

  // Reserved bits are not stored, so they always read back as zero.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      reg_loop_ff <= REG_LOOP_RST;
      reg_div1_ff <= REG_DIV1_RST;
      reg_div2_ff <= REG_DIV2_RST;
      reg_ctrl_ff <= REG_CTRL_RST;
    end else if (wr_pulse) begin
      if (reg_addr_ff == REG_LOOP_IDX) begin
        reg_loop_ff <= wr_data_ff & REG_LOOP_MASK;
      end else if (reg_addr_ff == REG_DIV1_IDX) begin
        reg_div1_ff <= wr_data_ff;
      end else if (reg_addr_ff == REG_DIV2_IDX) begin
        reg_div2_ff <= wr_data_ff;
      end else if (reg_addr_ff == REG_CTRL_IDX) begin
        reg_ctrl_ff <= wr_data_ff & REG_CTRL_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_word_ff    <= 16'h0000;
      rd_ack_tgl_ff <= 1'h0;
    end else if (rd_pulse) begin
      rd_word_ff    <= sel_word;
      rd_ack_tgl_ff <= rd_sync_ff[1];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stat_sync1_ff <= 3'h0;
      stat_sync2_ff <= 3'h0;
      stat_a        <= 1'h0;
      stat_b        <= 1'h0;
    end else begin
      stat_sync1_ff <= {refclk_status, refloss_status, lock_status};
      stat_sync2_ff <= stat_sync1_ff;
      stat_a <= |(stat_sync2_ff & reg_ctrl_ff[STAT_A_LSB +: 3]);
      stat_b <= |(stat_sync2_ff & reg_ctrl_ff[STAT_B_LSB +: 3]);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ref_div_ratio       <= 15'h0001;
      fb_a_ratio          <= 11'h001;
      fb_b_ratio          <= 9'h001;
      prescaler_one_ratio <= 3'h4;
      prescaler_two_ratio <= 3'h4;
      core_reset          <= 1'h0;
      divider_sync_force  <= 1'h0;
    end else begin
      ref_div_ratio <= {1'b0, reg_div1_ff[REFDIV_LSB +: 14]} + 15'h0001;
      fb_a_ratio    <= {1'b0, reg_div1_ff[FBA_HI_LSB +: 2], reg_div2_ff[FBA_LO_LSB +: 8]}
                       + 11'h001;
      fb_b_ratio    <= {1'b0, reg_div2_ff[FBB_LSB +: 8]} + 9'h001;
      prescaler_one_ratio <= ps_ratio(reg_ctrl_ff[PS_ONE_LSB +: 2]);
      prescaler_two_ratio <= ps_ratio(reg_ctrl_ff[PS_TWO_LSB +: 2]);
      core_reset          <= ~reg_ctrl_ff[RUN_BIT];
      divider_sync_force  <= ~reg_ctrl_ff[SYNC_BIT];
    end
  end

  assign loop_cap_sel           = reg_loop_ff[CAP_LSB +: 3];
  assign loop_res_sel           = reg_loop_ff[RES_LSB +: 3];
  assign pump_current_sel       = reg_loop_ff[PUMP_LSB +: 3];
  assign ref_divider_val        = reg_div1_ff[REFDIV_LSB +: 14];
  assign feedback_divider_a_val = {reg_div1_ff[FBA_HI_LSB +: 2], reg_div2_ff[FBA_LO_LSB +: 8]};
  assign feedback_divider_b_val = reg_div2_ff[FBB_LSB +: 8];
  assign cal_enable             = reg_ctrl_ff[CAL_BIT];
  assign prescaler_one_sel      = reg_ctrl_ff[PS_ONE_LSB +: 2];
  assign prescaler_two_sel      = reg_ctrl_ff[PS_TWO_LSB +: 2];

  // Link domain.
  assign link_rst   = reset | frame_clr_ff;
  assign addr_match = (shift_ff[7:1] == {SLAVE_ADDR_FIXED, lstrap_sync2_ff});

  // The strap value is static after reset; the synchroniser only guards
  // against the first frame arriving while it is still being captured.
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      lstrap_sync1_ff <= 2'h0;
      lstrap_sync2_ff <= 2'h0;
      ack_sync_ff     <= 2'h0;
    end else begin
      lstrap_sync1_ff <= strap_ff;
      lstrap_sync2_ff <= lstrap_sync1_ff;
      ack_sync_ff     <= {ack_sync_ff[0], rd_ack_tgl_ff};
    end
  end

  // Bit sequencing; any start or stop restarts it at the slave address.
  always_ff @(posedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      link_state_ff <= LINK_ADDR;
      bit_cnt_ff    <= 4'h0;
      shift_ff      <= 8'h00;
      tx_byte_ff    <= 1'h0;
    end else if (bit_cnt_ff != ACK_SLOT) begin
      shift_ff   <= {shift_ff[6:0], sda_in};
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else begin
      bit_cnt_ff <= 4'h0;
      case (link_state_ff)
        LINK_ADDR: begin
          if (!addr_match) begin
            link_state_ff <= LINK_IGNORE;
          end else if (shift_ff[0]) begin
            link_state_ff <= LINK_READ;
            tx_byte_ff    <= 1'h0;
          end else begin
            link_state_ff <= LINK_REG_HI;
          end
        end
        LINK_REG_HI: begin
          link_state_ff <= LINK_REG_LO;
        end
        LINK_REG_LO: begin
          link_state_ff <= LINK_DAT_HI;
        end
        LINK_DAT_HI: begin
          link_state_ff <= LINK_DAT_LO;
        end
        LINK_DAT_LO: begin
          link_state_ff <= LINK_DONE;
        end
        LINK_READ: begin
          if (sda_in || tx_byte_ff) begin
            link_state_ff <= LINK_IGNORE;
          end else begin
            tx_byte_ff <= 1'h1;
          end
        end
        default: begin
          link_state_ff <= link_state_ff;
        end
      endcase
    end
  end

  // Address, write data and request toggles survive repeated starts.
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      reg_addr_ff   <= 16'h0000;
      dat_hi_ff     <= 8'h00;
      wr_data_ff    <= 16'h0000;
      wr_tgl_ff     <= 1'h0;
      rd_req_tgl_ff <= 1'h0;
    end else if (bit_cnt_ff == ACK_SLOT) begin
      if (link_state_ff == LINK_REG_HI) begin
        reg_addr_ff[15:8] <= shift_ff;
      end else if (link_state_ff == LINK_REG_LO) begin
        reg_addr_ff[7:0] <= shift_ff;
        rd_req_tgl_ff    <= ~rd_req_tgl_ff;
      end else if (link_state_ff == LINK_DAT_HI) begin
        dat_hi_ff <= shift_ff;
      end else if (link_state_ff == LINK_DAT_LO) begin
        wr_data_ff <= {dat_hi_ff, shift_ff};
        wr_tgl_ff  <= ~wr_tgl_ff;
      end
    end
  end

  // A read whose fetch has not come back returns zero rather than a torn word.
  always_ff @(posedge scl_clk or posedge reset) begin
    if (reset) begin
      tx_word_ff <= 16'h0000;
    end else if (link_state_ff == LINK_ADDR && bit_cnt_ff == ACK_SLOT) begin
      tx_word_ff <= (ack_sync_ff[1] == rd_req_tgl_ff) ? rd_word_ff : 16'h0000;
    end
  end

  // The pin changes only on the falling clock edge, while the clock is low.
  always_ff @(negedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      sda_oe <= 1'h0;
    end else if (bit_cnt_ff == ACK_SLOT) begin
      case (link_state_ff)
        LINK_ADDR:   sda_oe <= addr_match;
        LINK_REG_HI: sda_oe <= 1'h1;
        LINK_REG_LO: sda_oe <= 1'h1;
        LINK_DAT_HI: sda_oe <= 1'h1;
        LINK_DAT_LO: sda_oe <= 1'h1;
        default:     sda_oe <= 1'h0;
      endcase
    end else if (link_state_ff == LINK_READ) begin
      sda_oe <= ~tx_word_ff[{~tx_byte_ff, ~bit_cnt_ff[2:0]}];
    end else begin
      sda_oe <= 1'h0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda_out <= 1'h0;
    end else begin
      sda_out <= 1'h0;
    end
  end

endmodule // pll_config_register_bank

`default_nettype wire

// ===== pll_cfg_pkg.sv
// Purpose: Shared constants for the PLL configuration register bank.
// Assumes: Registers are 16 bits wide and are indexed by a 16-bit register address.
// Notes:   Reset values and masks below are used by the bank and its bench.
//
// Summary of operation
// - Write is start, address+W, two address bytes, two data bytes, stop, each byte acked.
// - Read sends address bytes, repeated start, address+R, then device returns two bytes.
// - Registers 0 to 3 hold PLL and divider settings; others belong elsewhere.
// - Register 0 bits 9:7 select loop filter capacitor, 000 smallest, 111 largest.
// - Register 0 bits 6:4 select loop filter resistor, rising with the code.
// - Register 0 bits 3:1 select charge pump current, 0.5 mA steps.
// - Register 1 bits 15:2 are reference divider; ratio is value plus one.
// - Feedback divider A is register 1 bits 1:0 over register 2 bits 15:8, plus one.
// - Register 2 bits 7:0 are feedback divider B; ratio is value plus one.
// - Register 3 bits 12:10 enable refclk, refloss and lock onto status pin B.
// - Register 3 bits 9:7 enable refclk, refloss and lock onto status pin A.
// - Register 3 bit 6 low holds the core in reset, keeping register contents.
// - Register 3 bit 5 low forces divider synchronization; one releases it.
// - Register 3 bits 3:2 pick prescaler two: divide by 4, 5, 6; 11 reserved.
// - Register 3 bits 1:0 pick prescaler one: divide by 4, 5, 6; 11 reserved.
// - Slave address is fixed five bits over two pins sampled after reset.
// - Master NACK on a read byte ends the transfer; device goes idle.

`default_nettype none

package pll_cfg_pkg;

  localparam logic [15:0] REG_LOOP_IDX   = 16'h0000;
  localparam logic [15:0] REG_DIV1_IDX   = 16'h0001;
  localparam logic [15:0] REG_DIV2_IDX   = 16'h0002;
  localparam logic [15:0] REG_CTRL_IDX   = 16'h0003;

  localparam logic [15:0] REG_LOOP_RST   = 16'h0000;
  localparam logic [15:0] REG_DIV1_RST   = 16'h0000;
  localparam logic [15:0] REG_DIV2_RST   = 16'h0000;
  localparam logic [15:0] REG_CTRL_RST   = 16'h0060;

  localparam logic [15:0] REG_LOOP_MASK  = 16'h03FE;
  localparam logic [15:0] REG_CTRL_MASK  = 16'h1FFF;

  localparam int CAP_LSB     = 7;
  localparam int RES_LSB     = 4;
  localparam int PUMP_LSB    = 1;
  localparam int REFDIV_LSB  = 2;
  localparam int FBA_HI_LSB  = 0;
  localparam int FBA_LO_LSB  = 8;
  localparam int FBB_LSB     = 0;
  localparam int STAT_B_LSB  = 10;
  localparam int STAT_A_LSB  = 7;
  localparam int RUN_BIT     = 6;
  localparam int SYNC_BIT    = 5;
  localparam int CAL_BIT     = 4;
  localparam int PS_TWO_LSB  = 2;
  localparam int PS_ONE_LSB  = 0;

  localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h15;
  localparam logic [3:0] ACK_SLOT         = 4'h8;

  typedef enum logic [2:0] {
    LINK_ADDR   = 3'h0,
    LINK_REG_HI = 3'h1,
    LINK_REG_LO = 3'h3,
    LINK_DAT_HI = 3'h2,
    LINK_DAT_LO = 3'h6,
    LINK_DONE   = 3'h7,
    LINK_READ   = 3'h5,
    LINK_IGNORE = 3'h4
  } link_state_t;

endpackage

`default_nettype wire

// ===== pll_cfg_checker_properties.sv
// Purpose: Port checks for the PLL configuration register bank.
// Assumes: All checks sample on sys_clk; the bus clock is far slower.
// Notes:   Field updates land while the bus clock is high, just after its rising edge.
`timescale 1ns/1ps
`default_nettype none

module pll_cfg_checker (
  // Clocks and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        scl_clk,
  // Bus pin and status
  input wire logic        sda_oe,
  input wire logic        refclk_status,
  input wire logic        refloss_status,
  input wire logic        lock_status,
  input wire logic        stat_a,
  input wire logic        stat_b,
  // Register fields
  input wire logic [2:0]  loop_cap_sel,
  input wire logic [13:0] ref_divider_val,
  input wire logic [14:0] ref_div_ratio,
  input wire logic [9:0]  feedback_divider_a_val,
  input wire logic [10:0] fb_a_ratio,
  input wire logic [7:0]  feedback_divider_b_val,
  input wire logic [8:0]  fb_b_ratio,
  input wire logic [1:0]  prescaler_one_sel,
  input wire logic [1:0]  prescaler_two_sel,
  input wire logic [2:0]  prescaler_one_ratio,
  input wire logic [2:0]  prescaler_two_ratio
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // The pin may only move while the bus clock is low, or the host would see a false start.
  property p_ack_edge; $changed(sda_oe) |-> !scl_clk; endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("pin drive moved with clock high");
  property p_oe_quiet; $fell(reset) |-> (!sda_oe) [*3]; endproperty
  a_oe_quiet: assert property (p_oe_quiet) else $error("pin driven right after reset");
  property p_ref_ratio; ref_div_ratio == {1'b0, $past(ref_divider_val)} + 15'h1; endproperty
  a_ref_ratio: assert property (p_ref_ratio) else $error("reference ratio wrong");
  property p_fba_ratio; fb_a_ratio == {1'b0, $past(feedback_divider_a_val)} + 11'h1; endproperty
  a_fba_ratio: assert property (p_fba_ratio) else $error("feedback a ratio wrong");
  property p_fbb_ratio; fb_b_ratio == {1'b0, $past(feedback_divider_b_val)} + 9'h1; endproperty
  a_fbb_ratio: assert property (p_fbb_ratio) else $error("feedback b ratio wrong");
  property p_ps_one; $stable(prescaler_one_sel) |-> prescaler_one_ratio ==
    ((prescaler_one_sel == 2'h3) ? 3'h0 : {1'b1, prescaler_one_sel}); endproperty
  a_ps_one: assert property (p_ps_one) else $error("prescaler one ratio wrong");
  property p_ps_two; $stable(prescaler_two_sel) |-> prescaler_two_ratio ==
    ((prescaler_two_sel == 2'h3) ? 3'h0 : {1'b1, prescaler_two_sel}); endproperty
  a_ps_two: assert property (p_ps_two) else $error("prescaler two ratio wrong");
  property p_stat_idle;
    (!(refclk_status || refloss_status || lock_status)) [*6] |-> !stat_a && !stat_b;
  endproperty
  a_stat_idle: assert property (p_stat_idle) else $error("status pin set with no source");
  property p_cap_change; $changed(loop_cap_sel) |-> scl_clk; endproperty
  a_cap_change: assert property (p_cap_change) else $error("capacitor code moved off a write");
endmodule // pll_cfg_checker

bind pll_config_register_bank pll_cfg_checker u_checker (.*);

`default_nettype wire

// ===== i2c_host_model.sv
// Purpose: Bus host model that frames register writes and reads.
// Assumes: Timing counts are sys_clk cycles of 8 ns.
// Notes:   The bus clock stands high between frames; the data line has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  // Timing reference
  input  wire logic sys_clk,
  // Device drive of the data pin
  input  wire logic sda_oe,
  input  wire logic sda_out,
  // Bus wires
  output var  logic scl_clk,
  output var  logic sda_in
);
  // A quarter step of 82 cycles, 656 ns, keeps start hold and clock low time above their minimums.
  localparam int QTR = 82;
  logic sda_host = 1'b1;

  always_comb sda_in = sda_host & ~(sda_oe & ~sda_out);
  initial scl_clk = 1'b1;

  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic start();
    sda_host <= 1'b1;
    hold(QTR);
    scl_clk <= 1'b1;
    hold(QTR);
    sda_host <= 1'b0;
    hold(QTR);
    scl_clk <= 1'b0;
    hold(1);
  endtask

  task automatic stop();
    sda_host <= 1'b0;
    hold(2 * QTR);
    scl_clk <= 1'b1;
    hold(QTR);
    sda_host <= 1'b1;
    hold(QTR);
  endtask

  // Data moves only in the low phase and is sampled in the middle of the high phase.
  task automatic bit_x(input logic b, output logic r);
    sda_host <= b;
    hold(2 * QTR);
    scl_clk <= 1'b1;
    hold(QTR / 2);
    r = sda_in;
    hold(QTR / 2);
    scl_clk <= 1'b0;
    hold(1);
  endtask

  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack_n);
  endtask

  // The last byte of a read is answered with no acknowledge.
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule // i2c_host_model

`default_nettype wire

// ===== pll_config_register_bank_tb.sv
// Purpose: Self-checking bench for the PLL configuration register bank.
// Assumes: The host model drives the bus; a register model predicts every output but sda_out and sda_oe.
// Notes:   Straps and data come from a fixed seed; status sources sweep all eight codes.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got %0h exp %0h", $time, (g), (e)); end end

module pll_config_register_bank_tb;
  import pll_cfg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        scl_clk, sda_in, sda_out, sda_oe, addr_pin_hi, addr_pin_lo;
  logic        refclk_status = 1'b0, refloss_status = 1'b0, lock_status = 1'b0;
  logic        stat_a, stat_b, core_reset, divider_sync_force, cal_enable;
  logic [2:0]  loop_cap_sel, loop_res_sel, pump_current_sel;
  logic [13:0] ref_divider_val;
  logic [14:0] ref_div_ratio;
  logic [9:0]  feedback_divider_a_val;
  logic [10:0] fb_a_ratio;
  logic [7:0]  feedback_divider_b_val;
  logic [8:0]  fb_b_ratio;
  logic [1:0]  prescaler_one_sel, prescaler_two_sel;
  logic [2:0]  prescaler_one_ratio, prescaler_two_ratio;
  logic [15:0] mdl [4];
  logic [6:0]  sa;
  logic [15:0] rd_val;
  int          fail_count = 0;
  int          comparisons = 0;

  always #4 sys_clk = ~sys_clk;

  pll_config_register_bank dut (.*);
  i2c_host_model host (.sys_clk(sys_clk), .sda_oe(sda_oe), .sda_out(sda_out),
                       .scl_clk(scl_clk), .sda_in(sda_in));

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  function automatic logic [2:0] ps_ratio(input logic [1:0] c);
    return (c == 2'h3) ? 3'h0 : 3'h4 + 3'(c);
  endfunction

  task automatic check_outs();
    repeat (8) @(posedge sys_clk);
    `CHK(loop_cap_sel, mdl[0][9:7])
    `CHK(loop_res_sel, mdl[0][6:4])
    `CHK(pump_current_sel, mdl[0][3:1])
    `CHK(ref_div_ratio, {1'b0, mdl[1][15:2]} + 15'h1)
    `CHK(fb_a_ratio, {1'b0, mdl[1][1:0], mdl[2][15:8]} + 11'h1)
    `CHK(fb_b_ratio, {1'b0, mdl[2][7:0]} + 9'h1)
    `CHK(ref_divider_val, mdl[1][15:2])
    `CHK({feedback_divider_a_val, feedback_divider_b_val}, {mdl[1][1:0], mdl[2]})
    `CHK({prescaler_two_sel, prescaler_one_sel}, mdl[3][3:0])
    `CHK({core_reset, divider_sync_force, cal_enable}, {~mdl[3][6:5], mdl[3][4]})
    `CHK(prescaler_one_ratio, ps_ratio(mdl[3][1:0]))
    `CHK(prescaler_two_ratio, ps_ratio(mdl[3][3:2]))
  endtask

  // Every byte after a matching slave address is acked, mapped register or not.
  task automatic wr(input logic [6:0] a7, input logic [15:0] ra, input logic [15:0] d);
    logic [7:0] b [4];
    logic       ack_n;
    b = '{ra[15:8], ra[7:0], d[15:8], d[7:0]};
    host.start();
    host.put_byte({a7, 1'b0}, ack_n);
    `CHK(ack_n, a7 != sa)
    for (int i = 0; i < 4 && a7 == sa; i++) begin
      host.put_byte(b[i], ack_n);
      `CHK(ack_n, 1'b0)
    end
    host.stop();
    if (a7 == sa && ra < 16'h4) mdl[ra[1:0]] = d;
  endtask

  task automatic rd(input logic [15:0] ra, output logic [15:0] d);
    logic [7:0] b [4];
    logic       ack_n;
    b = '{{sa, 1'b0}, ra[15:8], ra[7:0], {sa, 1'b1}};
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 3) host.start();
      host.put_byte(b[i], ack_n);
      `CHK(ack_n, 1'b0)
    end
    host.get_byte(1'b0, d[15:8]);
    host.get_byte(1'b1, d[7:0]);
    `CHK(sda_oe, 1'b0)
    host.stop();
  endtask

  initial begin
    void'($urandom(67212));
    {addr_pin_hi, addr_pin_lo} = 2'($urandom);
    sa = {SLAVE_ADDR_FIXED, addr_pin_hi, addr_pin_lo};
    mdl = '{REG_LOOP_RST, REG_DIV1_RST, REG_DIV2_RST, REG_CTRL_RST};
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check_outs();
    $display("test reset values done");
    for (int k = 0; k < 4; k++) begin
      // Reserved bits go out as zero, as the host must send them.
      wr(sa, 16'(k), 16'($urandom) & (k == 0 ? REG_LOOP_MASK :
         k == 3 ? REG_CTRL_MASK : 16'hFFFF));
      check_outs();
    end
    $display("test register writes done");
    for (int s = 0; s < 8; s++) begin
      {refclk_status, refloss_status, lock_status} <= 3'(s);
      repeat (8) @(posedge sys_clk);
      `CHK(stat_b, |(mdl[3][12:10] & 3'(s)))
      `CHK(stat_a, |(mdl[3][9:7] & 3'(s)))
    end
    $display("test status pins done");
    rd(16'h0001, rd_val);
    `CHK(rd_val, mdl[1])
    $display("test register read done");
    wr(sa, 16'h0004, 16'($urandom));
    check_outs();
    wr(sa ^ 7'h01, 16'h0000, 16'hFFFF);
    check_outs();
    $display("test refused accesses done");
    results();
  end

  // A hang is cut short well above the expected run length.
  initial begin
    repeat (95000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule // pll_config_register_bank_tb

`default_nettype wire
